// ### usb_irq_regs.sv
/*
 * interrupt flag and enable registers, frame number register and endpoint
 * selector of a usb device controller, behind an apb slave.
 * assumes event inputs are one-cycle pulses synchronous to mclk_i, that the
 * endpoint register sets sit outside and answer through ep_rdata_i, and
 * that the apb master keeps to the protocol.
 */
`timescale 1ns/1ps

module usb_irq_regs
    import usb_irq_pkg::*;
#(
    parameter int NUM_IN_EP  = 15,  // in endpoints beyond endpoint 0
    parameter int NUM_OUT_EP = 15   // out endpoints beyond endpoint 0
) (
    input  wire logic        mclk_i,          // controller clock
    input  wire logic        rst_i,           // async reset, high
    input  wire logic        psel_i,          // apb select
    input  wire logic        penable_i,       // apb enable
    input  wire logic        pwrite_i,        // apb direction
    input  wire logic [11:0] paddr_i,         // apb byte address
    input  wire logic [31:0] pwdata_i,        // apb write data
    output logic      [31:0] prdata_o,        // apb read data
    output logic             pready_o,        // apb ready
    output logic             pslverr_o,       // apb error
    input  wire logic [15:0] in_ev_i,         // in endpoint event pulses
    input  wire logic [15:0] out_ev_i,        // out endpoint event pulses
    input  bus_events_t      bus_ev_i,        // bus event pulses
    input  wire logic        suspended_i,     // controller in suspend
    input  wire logic        frame_valid_i,   // new frame number strobe
    input  wire logic [10:0] frame_num_i,     // received frame number
    output logic [3:0]       ep_select_o,     // selected endpoint
    output logic             ep_win_sel_o,    // access in endpoint window
    input  wire logic [31:0] ep_rdata_i,      // window read data
    output logic             controller_irq_n // interrupt line, low
);
    // elaboration checks: the flag registers hold endpoints 0 to 15 only,
    // so a larger count would silently lose flags instead of failing loudly
    if (NUM_IN_EP < 0 || NUM_IN_EP > 15) begin : g_bad_in_count
        $error("NUM_IN_EP out of range");
    end
    if (NUM_OUT_EP < 0 || NUM_OUT_EP > 15) begin : g_bad_out_count
        $error("NUM_OUT_EP out of range");
    end

    // configured endpoint masks, endpoint 0 is never an out endpoint
    localparam logic [15:0] IN_CFG  = 16'((32'h1 << (NUM_IN_EP + 1)) - 1);
    localparam logic [15:0] OUT_CFG = 16'(((32'h1 << (NUM_OUT_EP + 1)) - 1) & 32'hfffe);

    // register map, one word per register, data in the low bits:
    //   in flags        read, clears on read
    //   out flags       read, clears on read, bit 0 always zero
    //   in enable       read/write, unconfigured bits forced to zero
    //   out enable      read/write, bit 0 and unconfigured bits zero
    //   bus flags       read, clears on read
    //   bus enable      read/write
    //   frame number    read only, bits 10:0
    //   selector        read/write, drives the endpoint window
    //   window          passed through from the selected endpoint sets
    // writes to read-only registers and unmapped addresses are dropped,
    // unmapped reads return zero; the bus never signals an error because
    // driver code polls these registers freely

    // per endpoint set terms, one generate slice per flag bit; an
    // endpoint left out of the build never raises its flag, so its bit
    // reads zero without any extra masking on the read path
    logic [15:0] in_set;    // in flag set terms
    logic [15:0] out_set;   // out flag set terms
    for (genvar b = 0; b < 16; b++) begin : g_ep_bit
        if (IN_CFG[b]) begin : g_in_on
            // configured in endpoint, ep0 included
            assign in_set[b] = in_ev_i[b];
        end else begin : g_in_off
            // absent in endpoint, tied off
            assign in_set[b] = 1'b0;
        end
        if (OUT_CFG[b]) begin : g_out_on
            // configured out endpoint
            assign out_set[b] = out_ev_i[b];
        end else begin : g_out_off
            // absent out endpoint or bit 0: the control endpoint only
            // ever reports through the in register
            assign out_set[b] = 1'b0;
        end
    end

    logic [15:0] in_flags_q,  in_flags_d;   // in flags, ep0 in bit 0
    logic [15:0] out_flags_q, out_flags_d;  // out flags
    logic [15:0] in_en_q,     in_en_d;      // in enable mask
    logic [15:0] out_en_q,    out_en_d;     // out enable mask
    logic [3:0]  bus_fl_q,    bus_fl_d;     // bus event flags
    logic [3:0]  bus_en_q,    bus_en_d;     // bus event enables
    logic [10:0] frame_q,     frame_d;      // last frame number
    logic [3:0]  sel_q,       sel_d;        // endpoint selector
    logic [31:0] rdata_q,     rdata_d;      // registered read data
    logic        irq_n_q,     irq_n_d;      // registered irq line

    // access phase strobes; everything a transfer does happens on the
    // first access edge, the wait state after it only presents the data
    logic       acc;      // access phase of any transfer
    logic       rd;       // first access cycle of a read
    logic       wr;       // first access cycle of a write
    logic       rd_in;    // read of the in flags, clears them
    logic       rd_out;   // read of the out flags, clears them
    logic       rd_bus;   // read of the bus event flags, clears them
    logic       win;      // address inside the endpoint window
    logic [3:0] bus_set;  // bus event set terms
    logic       wait_q;   // wait state of the current transfer
    logic       wait_d;   // next wait state
    // only the first access cycle acts, so a read clears exactly the
    // flags that it returns; a flag set in the wait state is kept
    assign acc = psel_i & penable_i;
    assign rd  = acc & ~wait_q & ~pwrite_i;
    assign wr  = acc & ~wait_q & pwrite_i;
    assign rd_in  = rd && paddr_i == `OFS_IN_FLAGS;
    assign rd_out = rd && paddr_i == `OFS_OUT_FLAGS;
    assign rd_bus = rd && paddr_i == `OFS_BUS_FLAGS;
    assign win = paddr_i >= `OFS_EP_WIN_LO && paddr_i <= `OFS_EP_WIN_HI;

    // bus event set terms; resume only counts while suspended, so a
    // stray resume on an awake bus cannot raise a spurious interrupt
    always_comb begin
        bus_set = 4'h0;
        bus_set[`BUS_EV_SOF]     = bus_ev_i.sof;
        bus_set[`BUS_EV_RESET]   = bus_ev_i.bus_reset;
        bus_set[`BUS_EV_RESUME]  = bus_ev_i.resume & suspended_i;
        bus_set[`BUS_EV_SUSPEND] = bus_ev_i.suspend;
    end

    // next state for flags, enables, frame, selector and read data
    always_comb begin
        // read clears first, a set in the same cycle survives it
        in_flags_d  = (rd_in  ? 16'h0000 : in_flags_q)  | in_set;
        out_flags_d = (rd_out ? 16'h0000 : out_flags_q) | out_set;
        bus_fl_d    = (rd_bus ? 4'h0 : bus_fl_q) | bus_set;
        in_en_d  = in_en_q;
        out_en_d = out_en_q;
        bus_en_d = bus_en_q;
        sel_d    = sel_q;
        frame_d  = frame_valid_i ? frame_num_i : frame_q;
        rdata_d  = rdata_q;
        // writes: enables are masked to the configured endpoints, flag
        // and frame addresses ignore writes
        if (wr) begin
            if (paddr_i == `OFS_IN_ENABLE) begin
                in_en_d = pwdata_i[15:0] & IN_CFG;
            end else if (paddr_i == `OFS_OUT_ENABLE) begin
                out_en_d = pwdata_i[15:0] & OUT_CFG;
            end else if (paddr_i == `OFS_BUS_ENABLE) begin
                bus_en_d = pwdata_i[3:0];
            end else if (paddr_i == `OFS_EP_SELECTOR) begin
                sel_d = pwdata_i[3:0];
            end
        end
        // reads: data latched on the first access edge, shown in the
        // wait state that follows
        if (rd) begin
            if (paddr_i == `OFS_IN_FLAGS) begin
                rdata_d = {16'h0000, in_flags_q};
            end else if (paddr_i == `OFS_OUT_FLAGS) begin
                rdata_d = {16'h0000, out_flags_q};
            end else if (paddr_i == `OFS_IN_ENABLE) begin
                rdata_d = {16'h0000, in_en_q};
            end else if (paddr_i == `OFS_OUT_ENABLE) begin
                rdata_d = {16'h0000, out_en_q};
            end else if (paddr_i == `OFS_BUS_FLAGS) begin
                rdata_d = {28'h0000000, bus_fl_q};
            end else if (paddr_i == `OFS_BUS_ENABLE) begin
                rdata_d = {28'h0000000, bus_en_q};
            end else if (paddr_i == `OFS_FRAME_NUMBER) begin
                rdata_d = {21'h000000, frame_q};
            end else if (paddr_i == `OFS_EP_SELECTOR) begin
                rdata_d = {28'h0000000, sel_q};
            end else if (win) begin
                rdata_d = ep_rdata_i;
            end else begin
                rdata_d = 32'h00000000;                                         // unmapped
            end
        end
        // line driven from the updated flags; one cycle of latency,
        // and it goes low on the same edge as the flag that causes it,
        // so software never sees the line before the flag
        irq_n_d = ~(|(in_flags_d & in_en_d) | |(out_flags_d & out_en_d)
                    | |(bus_fl_d & bus_en_d));
    end

    // register stage; enables come out of reset with every configured
    // endpoint enabled, bus events masked until software opts in
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            in_flags_q  <= 16'h0000;
            out_flags_q <= 16'h0000;
            in_en_q     <= IN_CFG;
            out_en_q    <= OUT_CFG;
            bus_fl_q    <= 4'h0;
            bus_en_q    <= `BUS_ENABLE_RST;
            frame_q     <= 11'h000;
            sel_q       <= `EP_SEL_RST;
            rdata_q     <= 32'h00000000;
            irq_n_q     <= 1'b1;
        end else begin
            in_flags_q  <= in_flags_d;
            out_flags_q <= out_flags_d;
            in_en_q     <= in_en_d;
            out_en_q    <= out_en_d;
            bus_fl_q    <= bus_fl_d;
            bus_en_q    <= bus_en_d;
            frame_q     <= frame_d;
            sel_q       <= sel_d;
            rdata_q     <= rdata_d;
            irq_n_q     <= irq_n_d;
        end
    end

    // read data is registered, so ready is held back one access cycle;
    // costs a wait state per transfer but keeps prdata off the decode path
    always_comb begin
        wait_d = acc & ~wait_q;
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
        end
    end

    // marks the first cycle after reset so the reset values of the enable
    // masks can be checked before any write has a chance to change them
    logic boot_q;   // high in the first cycle out of reset
    logic boot_d;   // next value, always low
    always_comb begin
        boot_d = 1'b0;
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= boot_d;
        end
    end

    // flags clear only on the first access edge; the window strobe is
    // raw decode, so the endpoint sets must not act on it alone but on
    // the access phase as well
    assign pready_o  = wait_q;
    assign pslverr_o = 1'b0;
    assign prdata_o  = rdata_q;
    assign ep_select_o  = sel_q;
    assign ep_win_sel_o = psel_i & win;
    assign controller_irq_n = irq_n_q;

    // assertions on flags, enables, the line and the bus answer
    a_out_bit0_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
        out_flags_q[0] == 1'b0 && out_en_q[0] == 1'b0)
        else $error("out bit 0 not zero");
    a_unconfig_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
        ((in_flags_q | in_en_q) & ~IN_CFG) == 16'h0
        && ((out_flags_q | out_en_q) & ~OUT_CFG) == 16'h0)
        else $error("unconfigured bit set");
    a_out_clear_read: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_out && out_ev_i == 16'h0 |=> out_flags_q == 16'h0)
        else $error("out flags not cleared");
    a_in_clear_read: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_in && in_ev_i == 16'h0 |=> in_flags_q == 16'h0)
        else $error("in flags not cleared");
    a_bus_clear_read: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_bus && bus_set == 4'h0 |=> bus_fl_q == 4'h0)
        else $error("bus flags not cleared");
    a_sof_sets: assert property (@(posedge mclk_i) disable iff (rst_i)
        bus_ev_i.sof |=> bus_fl_q[3])
        else $error("sof flag not set");
    a_reset_sets: assert property (@(posedge mclk_i) disable iff (rst_i)
        bus_ev_i.bus_reset |=> bus_fl_q[2])
        else $error("reset flag not set");
    a_resume_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
        !$past(bus_fl_q[1]) && !bus_fl_q[1] ##1 bus_fl_q[1] |-> $past(bus_ev_i.resume & suspended_i))
        else $error("resume without suspend");
    a_suspend_sets: assert property (@(posedge mclk_i) disable iff (rst_i)
        bus_ev_i.suspend |=> bus_fl_q[0])
        else $error("suspend flag not set");
    a_irq_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
        ##1 controller_irq_n == !(|(in_flags_q & in_en_q) | |(out_flags_q & out_en_q)
                                  | |(bus_fl_q & bus_en_q)))
        else $error("irq line mismatch");
    a_masked_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
        in_en_q == 16'h0 && out_en_q == 16'h0 && bus_en_q == 4'h0 ##1
        in_en_q == 16'h0 && out_en_q == 16'h0 && bus_en_q == 4'h0 |-> controller_irq_n)
        else $error("irq while all masked");
    a_frame_load: assert property (@(posedge mclk_i) disable iff (rst_i)
        frame_valid_i |=> frame_q == $past(frame_num_i))
        else $error("frame not captured");

    // reset values and register writes
    a_enable_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
        boot_q |-> in_en_q == IN_CFG && out_en_q == OUT_CFG)
        else $error("enable reset value wrong");
    a_in_en_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr && paddr_i == `OFS_IN_ENABLE |=> in_en_q == ($past(pwdata_i[15:0]) & IN_CFG))
        else $error("in enable write lost");
    a_out_en_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr && paddr_i == `OFS_OUT_ENABLE |=> out_en_q == ($past(pwdata_i[15:0]) & OUT_CFG))
        else $error("out enable write lost");
    a_bus_en_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr && paddr_i == `OFS_BUS_ENABLE |=> bus_en_q == $past(pwdata_i[3:0]))
        else $error("bus enable write lost");
    a_sel_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr && paddr_i == `OFS_EP_SELECTOR |=> ep_select_o == $past(pwdata_i[3:0]))
        else $error("selector write lost");

    // flag setting and the control endpoint
    a_ep0_not_out: assert property (@(posedge mclk_i) disable iff (rst_i)
        out_ev_i[0] |=> !out_flags_q[0])
        else $error("control endpoint in out flags");
    a_ctrl_in_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
        in_ev_i[0] |=> in_flags_q[0])
        else $error("control endpoint flag lost");
    a_in_sets: assert property (@(posedge mclk_i) disable iff (rst_i)
        in_set != 16'h0 |=> (in_flags_q & $past(in_set)) == $past(in_set))
        else $error("in flag not set");
    a_out_sets: assert property (@(posedge mclk_i) disable iff (rst_i)
        out_set != 16'h0 |=> (out_flags_q & $past(out_set)) == $past(out_set))
        else $error("out flag not set");
    a_resume_blocked: assert property (@(posedge mclk_i) disable iff (rst_i)
        bus_ev_i.resume && !suspended_i && !bus_fl_q[1] |=> !bus_fl_q[1])
        else $error("resume set while awake");
    a_irq_release: assert property (@(posedge mclk_i) disable iff (rst_i)
        (in_flags_q | out_flags_q) == 16'h0 && bus_fl_q == 4'h0 |-> controller_irq_n)
        else $error("irq line stuck low");

    // bus answer and endpoint window
    a_one_wait: assert property (@(posedge mclk_i) disable iff (rst_i)
        acc && !wait_q |=> pready_o)
        else $error("ready not after one wait");
    a_ready_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
        !acc |-> !pready_o)
        else $error("ready outside access");
    a_win_data: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd && win |=> prdata_o == $past(ep_rdata_i))
        else $error("window data not passed");

    c_out_read: cover property (@(posedge mclk_i) disable iff (rst_i) rd_out && out_flags_q != 16'h0);
    c_irq_low: cover property (@(posedge mclk_i) disable iff (rst_i) !controller_irq_n);
    c_resume_hit: cover property (@(posedge mclk_i) disable iff (rst_i) bus_set[1]);
    c_win_read: cover property (@(posedge mclk_i) disable iff (rst_i) rd && win);
    // a flag that sets while its enable is off, the silent case
    c_masked_set: cover property (@(posedge mclk_i) disable iff (rst_i)
        (in_set & ~in_en_q) != 16'h0);
endmodule

// ### usb_irq_consts.svh
/*
 * register offsets, reset values, field positions and sizes for the usb
 * device interrupt, frame number and endpoint selector block.
 * assumes inclusion by bare name from the package only.
 */
`ifndef USB_IRQ_CONSTS_SVH
`define USB_IRQ_CONSTS_SVH

// register indices; not all of them are word aligned, so each register
// takes one 32-bit word and its apb byte address is four times the index
`define IDX_IN_FLAGS        12'h002
`define IDX_OUT_FLAGS       12'h004
`define IDX_IN_ENABLE       12'h006
`define IDX_OUT_ENABLE      12'h008
`define IDX_BUS_FLAGS       12'h00a
`define IDX_BUS_ENABLE      12'h00b
`define IDX_FRAME_NUMBER    12'h00c
`define IDX_EP_SELECTOR     12'h00e
// window whose registers follow the endpoint selector
`define IDX_EP_WIN_LO       12'h010
`define IDX_EP_WIN_HI       12'h019

// byte addresses on the apb register bus
`define OFS_IN_FLAGS        (`IDX_IN_FLAGS << 2)
`define OFS_OUT_FLAGS       (`IDX_OUT_FLAGS << 2)
`define OFS_IN_ENABLE       (`IDX_IN_ENABLE << 2)
`define OFS_OUT_ENABLE      (`IDX_OUT_ENABLE << 2)
`define OFS_BUS_FLAGS       (`IDX_BUS_FLAGS << 2)
`define OFS_BUS_ENABLE      (`IDX_BUS_ENABLE << 2)
`define OFS_FRAME_NUMBER    (`IDX_FRAME_NUMBER << 2)
`define OFS_EP_SELECTOR     (`IDX_EP_SELECTOR << 2)
`define OFS_EP_WIN_LO       (`IDX_EP_WIN_LO << 2)
`define OFS_EP_WIN_HI       (`IDX_EP_WIN_HI << 2)

// bus event flag positions
`define BUS_EV_SOF          3
`define BUS_EV_RESET        2
`define BUS_EV_RESUME       1
`define BUS_EV_SUSPEND      0

// widths
`define FRAME_BITS          11
`define EP_SEL_BITS         4
`define BUS_EV_BITS         4

// reset values
`define BUS_ENABLE_RST      4'h0
`define EP_SEL_RST          4'h0

`endif

// ### usb_irq_pkg.sv
/*
 * types shared by the usb device interrupt block.
 * assumes the constants header is on the include path.
 */
package usb_irq_pkg;
    `include "usb_irq_consts.svh"

    // one bus event report from the packet engine, one-cycle pulses
    typedef struct packed {
        logic sof;       // start of frame seen
        logic bus_reset; // reset signalling seen
        logic resume;    // resume signalling seen
        logic suspend;   // suspend signalling seen
    } bus_events_t;

    // apb access phase decode
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SETUP  = 3'b010,
        ST_ACCESS = 3'b100
    } apb_phase_t;
endpackage

// ### usb_host_model.sv
/*
 * partner model: the usb host and hub side, source of bus events,
 * suspend state and received frame numbers.
 * assumes its tasks are called just after a rising edge of mclk_i.
 */
`timescale 1ns/1ps
module usb_host_model
    import usb_irq_pkg::*;
(
    input  wire logic   mclk_i,        // controller clock
    output bus_events_t bus_ev_o,      // one-cycle bus event pulses
    output logic        suspended_o,   // controller suspend level
    output logic        frame_valid_o, // frame number strobe
    output logic [10:0] frame_num_o    // received frame number
);
    // quiet bus at start
    initial begin
        bus_ev_o = '0;
        suspended_o = 1'b0;
        frame_valid_o = 1'b0;
        frame_num_o = 11'h2a5;
    end

    // one event pulse; suspend level chosen by the caller and left standing
    task automatic pulse_events(input bus_events_t v, input logic susp);
        suspended_o <= susp;
        bus_ev_o <= v;
        @(posedge mclk_i);
        bus_ev_o <= '0;
    endtask

    // frame strobe; number goes stale (inverted) so a late sample shows up
    task automatic send_frame(input logic [10:0] n);
        frame_valid_o <= 1'b1;
        frame_num_o <= n;
        @(posedge mclk_i);
        frame_valid_o <= 1'b0;
        frame_num_o <= ~n;
    endtask
endmodule

// ### usb_irq_regs_test.sv
/*
 * self-checking bench for the usb interrupt, frame and selector registers.
 * assumes the design answers apb with one wait state and the host model
 * stands for the bus side.
 */
`timescale 1ns/1ps
module usb_irq_regs_test;
    import usb_irq_pkg::*;
    `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
    localparam logic [15:0] IN_MASK  = 16'h003f; // ep0 plus five in endpoints
    localparam logic [15:0] OUT_MASK = 16'h000e; // three out endpoints
    logic        mclk_i = 1'b0;  // bench clock
    logic        rst_i = 1'b1;   // async reset
    logic        psel = 1'b0;    // apb select
    logic        penable = 1'b0; // apb enable
    logic        pwrite = 1'b0;  // apb direction
    logic [11:0] paddr = '0;     // apb address
    logic [31:0] pwdata = '0;    // apb write data
    logic [31:0] ep_rdata = '0;  // window read data
    logic [15:0] in_ev = '0;     // in endpoint pulses
    logic [15:0] out_ev = '0;    // out endpoint pulses
    logic [31:0] prdata;         // read data
    logic        pready;         // apb ready
    logic        irq_n;          // interrupt line
    logic [3:0]  ep_sel;         // selected endpoint
    logic        susp;           // suspend level
    logic        fvalid;         // frame strobe
    logic [10:0] fnum;           // frame number
    bus_events_t bus_ev;         // bus events
    logic [31:0] expq[$];        // expected read data
    logic [31:0] exp_v;          // oldest expectation
    logic [31:0] r;              // random draw
    int          failures = 0;   // mismatches
    int          n_compared = 0; // comparisons

    always #2 mclk_i = ~mclk_i;

    usb_host_model usb_host_model_inst (.mclk_i(mclk_i), .bus_ev_o(bus_ev),
        .suspended_o(susp), .frame_valid_o(fvalid), .frame_num_o(fnum));
    usb_irq_regs #(.NUM_IN_EP(5), .NUM_OUT_EP(3)) usb_irq_regs_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(), .in_ev_i(in_ev), .out_ev_i(out_ev),
        .bus_ev_i(bus_ev), .suspended_i(susp), .frame_valid_i(fvalid),
        .frame_num_i(fnum), .ep_select_o(ep_sel), .ep_win_sel_o(),
        .ep_rdata_i(ep_rdata), .controller_irq_n(irq_n));

    // read completions checked against the oldest note
    always @(posedge mclk_i) begin
        if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) begin
            exp_v = expq.pop_front();
            `CHK(prdata, exp_v)
        end
    end

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1) @(posedge mclk_i);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // endpoint pulses, then let the flags and line settle
    task automatic ev(input logic [15:0] i, input logic [15:0] o);
        in_ev <= i;
        out_ev <= o;
        @(posedge mclk_i);
        in_ev <= '0;
        out_ev <= '0;
        repeat (2) @(posedge mclk_i);
    endtask

    task automatic finish_test;
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk_i);
        failures++;
        finish_test();
    end

    // main sequence
    initial begin
        r = $urandom(85);
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        `CHK(irq_n, 1'b1)
        rd(`OFS_IN_ENABLE, 32'(IN_MASK));
        rd(`OFS_OUT_ENABLE, 32'(OUT_MASK));
        rd(`OFS_EP_SELECTOR, 32'h0);
        apb(1'b1, `OFS_IN_ENABLE, 32'hffffffff);
        apb(1'b1, `OFS_OUT_ENABLE, 32'hffffffff);
        rd(`OFS_IN_ENABLE, 32'(IN_MASK));
        rd(`OFS_OUT_ENABLE, 32'(OUT_MASK));
        repeat (4) begin
            r = $urandom();
            ev(r[15:0], r[31:16]);
            `CHK(irq_n, ~|((r[15:0] & IN_MASK) | (r[31:16] & OUT_MASK)))
            rd(`OFS_IN_FLAGS, 32'(r[15:0] & IN_MASK));
            rd(`OFS_OUT_FLAGS, 32'(r[31:16] & OUT_MASK));
            rd(`OFS_IN_FLAGS, 32'h0);
            rd(`OFS_OUT_FLAGS, 32'h0);
            `CHK(irq_n, 1'b1)
        end
        ev(16'h0000, 16'h0001);
        rd(`OFS_OUT_FLAGS, 32'h0);
        // masked flags set silently
        apb(1'b1, `OFS_IN_ENABLE, 32'h0);
        apb(1'b1, `OFS_OUT_ENABLE, 32'h0);
        ev(16'h0021, 16'h0008);
        `CHK(irq_n, 1'b1)
        rd(`OFS_IN_FLAGS, 32'h21);
        rd(`OFS_OUT_FLAGS, 32'h8);
        // bus events, one bit at a time, all enabled
        apb(1'b1, `OFS_BUS_ENABLE, 32'hf);
        rd(`OFS_BUS_ENABLE, 32'hf);
        for (int i = 0; i < 4; i++) begin
            usb_host_model_inst.pulse_events(bus_events_t'(4'(1 << i)), 1'b1);
            repeat (2) @(posedge mclk_i);
            `CHK(irq_n, 1'b0)
            rd(`OFS_BUS_FLAGS, 32'(1 << i));
            rd(`OFS_BUS_FLAGS, 32'h0);
        end
        usb_host_model_inst.pulse_events(bus_events_t'(4'h2), 1'b0);
        repeat (2) @(posedge mclk_i);
        rd(`OFS_BUS_FLAGS, 32'h0);
        apb(1'b1, `OFS_BUS_ENABLE, 32'h0);
        usb_host_model_inst.pulse_events(bus_events_t'(4'h8), 1'b0);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_n, 1'b1)
        rd(`OFS_BUS_FLAGS, 32'h8);
        r = $urandom();
        usb_host_model_inst.send_frame(r[10:0]);
        rd(`OFS_FRAME_NUMBER, 32'(r[10:0]));
        // endpoint selector and its window; selector written first
        ep_rdata <= r;
        apb(1'b1, `OFS_EP_SELECTOR, 32'(r[19:16]));
        `CHK(ep_sel, r[19:16])
        rd(`OFS_EP_SELECTOR, 32'(r[19:16]));
        rd(`OFS_EP_WIN_LO, r);
        rd(12'h080, 32'h0);
        finish_test();
    end
endmodule
